// File: core/lrs_lut_ram.v
// Lookup-table storage used as 16x1/32x1 distributed RAM or as a
// 16-stage addressable shift register with cascade stream.
// Assumes all inputs come from logic on i_clock; one clock only.
//
// Summary of operation
// - Write enable stores bit_in at address
// - Written bit appears on output after edge
// - Read follows address combinationally when idle
// - Sixteen by one RAM organisation supported
// - Thirty-two by one via paired tables
// - Written bit also routed to wide mux, except 16x1 writes with addr[4] high
// - Cascade output carries last stage bit
// - Shift only while shift enable high
// - Sixteen stages; first bit exits after sixteen
`timescale 1ns/100ps
`include "lrs_map.vh"
`default_nettype none

module lrs_fifo #(
	parameter WIDTH = `LRS_FIFO_W,
	parameter DEPTH = `LRS_FIFO_DEPTH,
	parameter PTR_W = `LRS_FIFO_PTR_W
) (
	input  wire             i_clock,    // Block clock
	input  wire             i_rst_n,    // Synchronous reset, active low
	input  wire [WIDTH-1:0] i_wr_data,  // Word to store
	input  wire             i_wr_valid, // Word offered
	output wire             o_wr_ready, // Room for a word
	output wire [WIDTH-1:0] o_rd_data,  // Oldest word
	output wire             o_rd_valid, // Oldest word present
	input  wire             i_rd_ready  // Consumer takes word
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [PTR_W:0]   wr_ptr_q;
	reg [PTR_W:0]   rd_ptr_q;
	wire            push;
	wire            pop;

	// Extra pointer bit separates full from empty
	assign o_wr_ready = (wr_ptr_q[PTR_W] == rd_ptr_q[PTR_W]) ||
		(wr_ptr_q[PTR_W-1:0] != rd_ptr_q[PTR_W-1:0]);
	assign o_rd_valid = (wr_ptr_q != rd_ptr_q);
	assign o_rd_data  = mem_q[rd_ptr_q[PTR_W-1:0]];
	assign push       = i_wr_valid && o_wr_ready;
	assign pop        = o_rd_valid && i_rd_ready;

	// Storage words carry no reset
	always @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_ptr_q[PTR_W-1:0]] <= i_wr_data;
		end
	end

	// Pointers
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			wr_ptr_q <= {(PTR_W+1){1'b0}};
			rd_ptr_q <= {(PTR_W+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end
endmodule // lrs_fifo

module lrs_lut_ram (
	input  wire                   i_clock,       // Block clock, 40 MHz
	input  wire                   i_rst_n,       // Synchronous reset, active low
	input  wire                   i_mode,        // 0 RAM, 1 shift register
	input  wire                   i_ram32,       // RAM as 32x1 when high
	input  wire [`LRS_ADDR_W-1:0] i_lut_addr,    // Lookup-table address inputs
	input  wire                   i_bypass,      // Bypass input, source of bit_in
	input  wire                   i_setreset,    // Write enable in RAM use
	input  wire                   i_clk_gate_in, // Write enable in shift use
	output wire [1:0]             o_lut_out_pair,// Addressed bit of each table
	output wire                   o_wide_mux_out,// Table pair selected by addr[4]
	output wire                   o_tail_tap,    // Last shift stage
	output wire                   o_cascade_out, // Cascade bit to next shifter
	output wire                   o_shift_ready, // FIFO has room, so a requested shift is taken this edge
	output wire                   o_casc_valid,  // Cascade stream word valid
	output wire                   o_casc_data,   // Cascade stream word
	input  wire                   i_casc_ready   // Cascade stream consumer ready
);
	reg  [`LRS_LUT_DEPTH-1:0]  lut_f_q;   // Low table, also the shifter
	reg  [`LRS_LUT_DEPTH-1:0]  lut_g_q;   // High table
	wire                       bit_in;
	wire [`LRS_LUT_ADDR_W-1:0] lut_idx;
	wire                       ram_we;
	wire                       shift_en;
	wire                       fifo_ready;
	genvar                     gi;

	assign bit_in  = i_bypass;
	assign lut_idx = i_lut_addr[`LRS_LUT_ADDR_W-1:0];
	assign ram_we  = (i_mode == `LRS_MODE_RAM) && i_setreset;
	// Shifting stalls when the cascade stream cannot take the stage 14 bit
	assign shift_en = (i_mode == `LRS_MODE_SHIFT) && i_clk_gate_in
		&& fifo_ready;

	// One generate per stage; no reset reaches storage
	generate
		for (gi = 0; gi < `LRS_LUT_DEPTH; gi = gi + 1) begin : g_cell
			always @(posedge i_clock) begin
				if (shift_en) begin
					// Stage 0 takes the new bit, others take the neighbour
					lut_f_q[gi] <= (gi == 0) ? bit_in : lut_f_q[(gi == 0) ? 0 : gi-1];
				end else if (ram_we && (lut_idx == gi) &&
					(!i_ram32 || !i_lut_addr[`LRS_ADDR_W-1])) begin
					lut_f_q[gi] <= bit_in;
				end
				if (ram_we && i_ram32 && i_lut_addr[`LRS_ADDR_W-1] &&
					(lut_idx == gi)) begin
					lut_g_q[gi] <= bit_in;
				end
			end
		end
	endgenerate

	// Reads are asynchronous so an address change shows at once; the
	// stored bit itself comes from a flop, giving write-first after an edge
	assign o_lut_out_pair = {lut_g_q[lut_idx], lut_f_q[lut_idx]};
	assign o_wide_mux_out = i_lut_addr[`LRS_ADDR_W-1] ?
		lut_g_q[lut_idx] : lut_f_q[lut_idx];
	assign o_tail_tap     = lut_f_q[`LRS_TAIL_STAGE];
	assign o_cascade_out  = lut_f_q[`LRS_TAIL_STAGE];
	assign o_shift_ready  = fifo_ready;

	// Each shift pushes the stage 14 bit, the one moving into the last stage, downstream
	lrs_fifo #(
		.WIDTH (`LRS_FIFO_W),
		.DEPTH (`LRS_FIFO_DEPTH),
		.PTR_W (`LRS_FIFO_PTR_W)
	) u_casc_fifo (
		.i_clock    (i_clock),
		.i_rst_n    (i_rst_n),
		.i_wr_data  (lut_f_q[`LRS_TAIL_STAGE-1]),
		.i_wr_valid (shift_en),
		.o_wr_ready (fifo_ready),
		.o_rd_data  (o_casc_data),
		.o_rd_valid (o_casc_valid),
		.i_rd_ready (i_casc_ready)
	);
endmodule // lrs_lut_ram

`default_nettype wire

// File: core/lrs_map.vh
// Constants for the lookup-table RAM and shift register block.
// Included by bare name by the core design file.
`ifndef LRS_MAP_VH
`define LRS_MAP_VH

`define LRS_LUT_DEPTH   16   // Entries in one lookup table
`define LRS_PAIR_DEPTH  32   // Entries across the paired tables
`define LRS_ADDR_W      5    // Address width for the paired tables
`define LRS_LUT_ADDR_W  4    // Address width for one table
`define LRS_TAIL_STAGE  15   // Index of the last shift stage
`define LRS_MODE_RAM    1'h0 // Storage used as distributed RAM
`define LRS_MODE_SHIFT  1'h1 // Storage used as addressable shifter
`define LRS_FIFO_W      1    // Width of a cascade FIFO word
`define LRS_FIFO_DEPTH  32   // Words held by the cascade FIFO
`define LRS_FIFO_PTR_W  5    // Pointer width for the cascade FIFO

`endif

// File: tb/lrs_chk_monitor.sv
// Port checker for lrs_lut_ram, one clock domain.
// Assumes it is bound onto the design top by port name.
`timescale 1ns/100ps
`default_nettype none
module lrs_chk (
	input wire logic       i_clock, i_rst_n, i_mode, i_ram32, i_bypass, // Inputs
	input wire logic       i_setreset, i_clk_gate_in, i_casc_ready,     // Enables
	input wire logic [4:0] i_lut_addr,                                 // Address
	input wire logic [1:0] o_lut_out_pair,                             // Table bits
	input wire logic       o_wide_mux_out, o_tail_tap, o_cascade_out,  // Taps
	input wire logic       o_shift_ready, o_casc_valid, o_casc_data    // Stream
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// Taken requests, mode exclusive
	wire wr = !i_mode && i_setreset;
	wire sh = i_mode && i_clk_gate_in && o_shift_ready;
	sequence s_shift; sh; endsequence
	sequence s_run16; s_shift [*8] ##1 s_shift [*8]; endsequence
	a_ram_low: assert property (wr && !(i_ram32 && i_lut_addr[4]) ##1 $stable(i_lut_addr)
		|-> o_lut_out_pair[0] == $past(i_bypass)) else $error("low table write lost");
	a_ram_high: assert property (wr && i_ram32 && i_lut_addr[4] ##1 $stable(i_lut_addr)
		|-> o_lut_out_pair[1] == $past(i_bypass)) else $error("high table write lost");
	a_wide_sel: assert property (o_wide_mux_out === o_lut_out_pair[i_lut_addr[4]])
		else $error("wide mux wrong table");
	a_casc_tail: assert property (o_cascade_out === o_tail_tap)
		else $error("cascade differs from tail");
	a_shift_hold: assert property (!sh && !wr |=> o_tail_tap === $past(o_tail_tap))
		else $error("tail moved without shift");
	a_shift_in: assert property (s_shift ##0 i_lut_addr[3:0] == 4'h0 ##1 $stable(i_lut_addr)
		|-> o_lut_out_pair[0] == $past(i_bypass)) else $error("shifted bit not at stage 0");
	a_push_word: assert property (s_shift ##0 !o_casc_valid
		|=> o_casc_valid && o_casc_data === o_tail_tap) else $error("cascade word missing");
	a_depth_sixteen: assert property (s_run16 |=> o_tail_tap == $past(i_bypass, 16))
		else $error("first bit not out after sixteen");
endmodule // lrs_chk
`default_nettype wire

// File: tb/lrs_casc_sink.sv
// Consumer of the cascade stream, standing in for downstream logic.
// Assumes the shared clock; stalls fully while i_hold is high.
`timescale 1ns/100ps
`default_nettype none
module lrs_casc_sink (
	input  wire logic i_clock, // Shared clock
	input  wire logic i_hold,  // Stall every pop
	output var logic  o_ready  // Takes a word
);
	logic [3:0] lfsr_q = 4'h1;
	// Irregular stalls, so the FIFO sees both quick and slow drains
	always @(posedge i_clock) begin
		lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
		o_ready <= !i_hold && lfsr_q[0];
	end
endmodule // lrs_casc_sink
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for lrs_lut_ram with its cascade sink.
// Assumes the checker and sink are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic       i_clock = 0, i_rst_n = 0, i_mode = 0, i_ram32 = 0, i_bypass = 0, hold = 0;
	logic       i_setreset = 0, i_clk_gate_in = 0;
	logic [4:0] i_lut_addr = 5'h00;
	wire  [1:0] o_lut_out_pair;
	wire        o_wide_mux_out, o_tail_tap, o_cascade_out, o_shift_ready;
	wire        o_casc_valid, o_casc_data, i_casc_ready;
	logic       lo [16], hi [16], q [$];
	int         miscompares = 0, checks_done = 0, cycles = 0;
	integer     seed = 32'hCC5F0891;
	lrs_lut_ram i_dut (.*);
	lrs_casc_sink i_sink (.i_clock, .i_hold(hold), .o_ready(i_casc_ready));
	initial forever #12.5 i_clock = ~i_clock;
	// Reference bit on the wide mux for an address
	function automatic logic exp_wide(input logic [4:0] a);
		return a[4] ? hi[a[3:0]] : lo[a[3:0]];
	endfunction
	task automatic chk(input logic ok);
		checks_done++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("wrong value at %0t: output differs from model", $time);
		end
	endtask
	// One request per edge; reference updated for the edge that takes it
	task automatic cyc(input logic m, r, g, s, input logic [4:0] a);
		logic b;
		b = $random(seed);
		@(posedge i_clock);
		{i_mode, i_ram32, i_clk_gate_in, i_setreset, i_lut_addr, i_bypass} <= {m, r, g, s, a, b};
		@(negedge i_clock);
		chk(o_lut_out_pair === {hi[a[3:0]], lo[a[3:0]]});
		chk(o_wide_mux_out === exp_wide(a));
		chk({o_tail_tap, o_cascade_out} === {2{lo[15]}});
		chk({o_casc_valid, o_shift_ready} === {q.size() != 0, q.size() < 32});
		if (o_casc_valid && i_casc_ready) chk(o_casc_data === q.pop_front());
		if (!m && s) begin
			if (r && a[4]) hi[a[3:0]] = b;
			else lo[a[3:0]] = b;
		end
		if (m && g && o_shift_ready) begin
			q.push_back(lo[14]);
			for (int i = 15; i > 0; i--) lo[i] = lo[i - 1];
			lo[0] = b;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Guard against a hang; the run needs about 600 cycles
	always @(posedge i_clock) if (++cycles == 3000) begin
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge i_clock);
		i_rst_n <= 1'b1;
		for (int a = 0; a < 32; a++) cyc(0, 1, 0, 1, a[4:0]);
		// Write then hold the address, so write-first readback is seen
		cyc(0, 0, 0, 1, 5'h13);
		cyc(0, 0, 0, 0, 5'h13);
		cyc(0, 1, 0, 1, 5'h1A);
		cyc(0, 1, 0, 0, 5'h1A);
		$display("fill of both tables done");
		hold = 1;
		repeat (40) cyc(1, 0, 1, 1, $random(seed));
		hold = 0;
		$display("full FIFO refusal done");
		repeat (100) cyc(1, 1, 0, 1, $random(seed));
		repeat (20) cyc(1, 0, 1, 0, 5'h00);
		$display("drain and burst done");
		@(posedge i_clock);
		{i_rst_n, i_setreset, i_clk_gate_in} <= 3'h0;
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		q.delete();
		repeat (400) cyc($random(seed), $random(seed), $random(seed), $random(seed), $random(seed));
		$display("random mix done");
		complete_run;
	end
endmodule // tb_top
bind lrs_lut_ram lrs_chk u_chk (.*);
`default_nettype wire
